// File: sense_defs.svh
// constants for the sensor function-command block
// assumes pclk runs at 50 MHz
`ifndef SENSE_DEFS_SVH
`define SENSE_DEFS_SVH
`define CLK_NS      20
`define T_HOLD_US   15
`define T_SAMPLE_US 30
`define T_PWAIT_US  30
`define T_PRES_US   120
`define T_RESET_US  480
`define T_CONV_MS   750
`define T_COPY_MS   10
// least times round up, longest times round down
`define HOLD_CYC   ((`T_HOLD_US*1000)/`CLK_NS)
`define SAMPLE_CYC ((`T_SAMPLE_US*1000)/`CLK_NS)
`define PWAIT_CYC  ((`T_PWAIT_US*1000+`CLK_NS-1)/`CLK_NS)
`define PRES_CYC   ((`T_PRES_US*1000+`CLK_NS-1)/`CLK_NS)
`define RESET_CYC  ((`T_RESET_US*1000+`CLK_NS-1)/`CLK_NS)
`define CONV_CYC   ((`T_CONV_MS*1000000)/`CLK_NS)
`define COPY_CYC   ((`T_COPY_MS*1000000)/`CLK_NS)
// line codes
`define ROM_SKIP   8'hCC
`define CMD_CONV   8'h44
`define CMD_RECALL 8'hB8
`define CMD_POWER  8'hB4
`define CMD_COPY   8'h48
`define CMD_WRITE  8'h4E
`define CMD_READ   8'hBE
`define CRC_POLY   8'h8C
`define SP_RSVD    8'hFF
`define SP_LAST    4'h8
// reset values
`define NV_HIGH_RST 8'h4B
`define NV_LOW_RST  8'h46
`define SRC_RST     32'h0000_0000
// register map
`define REG_CTRL   8'h00
`define REG_SRC    8'h04
`define REG_STAT   8'h08
`define REG_TRIG   8'h0C
`define REG_TEMP   8'h10
`define CTRL_EXT_BIT 0
`endif

// File: sense_pkg.sv
// types for the sensor function-command block
// shared by the slot engine, the timers and the top
package sense_pkg;
  typedef enum logic [4:0] {
    E_IDLE  = 5'h01,
    E_SLOT  = 5'h02,
    E_RLOW  = 5'h04,
    E_PWAIT = 5'h08,
    E_PRES  = 5'h10
  } eng_st_t;

  typedef enum logic [7:0] {
    F_HALT = 8'h01,
    F_ROM  = 8'h02,
    F_FUNC = 8'h04,
    F_WRT  = 8'h08,
    F_RDSP = 8'h10,
    F_CONV = 8'h20,
    F_COPY = 8'h40,
    F_PWR  = 8'h80
  } fn_st_t;

  typedef struct packed {
    eng_st_t     st;
    logic [15:0] cnt;
    logic        oe;
    logic        prev;
    logic        strobe;
    logic        val;
    logic        rst;
  } eng_q_t;

  typedef struct packed {
    logic [25:0] cnt;
    logic        busy;
    logic        done;
  } timer_q_t;

  typedef struct packed {
    fn_st_t      st;
    logic [7:0]  rx;
    logic [2:0]  bits;
    logic [3:0]  idx;
    logic [7:0]  crc;
    logic [7:0]  txb;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [7:0]  nv_hi;
    logic [7:0]  nv_lo;
    logic        ext_pwr;
    logic [31:0] src;
    logic [31:0] temp;
    logic        recall;
    logic        conv_go;
    logic        copy_go;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        dq_out;
  } fn_q_t;
endpackage : sense_pkg

// File: slot_if.sv
// carrier between the slot engine and the command logic
// both ends run on pclk
`timescale 1ns/100ps
interface slot_if;
  logic rst_pulse;
  logic bit_strobe;
  logic bit_val;
  logic tx_en;
  logic tx_bit;
  logic dq_oe;
  modport eng (output rst_pulse, bit_strobe, bit_val, dq_oe, input tx_en, tx_bit);
  modport ctl (input rst_pulse, bit_strobe, bit_val, dq_oe, output tx_en, tx_bit);
endinterface : slot_if

// File: busy_timer.sv
// busy timer for conversion and copy
// assumes start is a one-cycle pulse on pclk
`timescale 1ns/100ps
module busy_timer #(
  parameter int unsigned LEN = 1
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  import sense_pkg::*;
  timer_q_t q, d;

  // a start during a run is ignored, the run is not stretched
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (q.busy) begin
      d.cnt = q.cnt + 26'h1;
      if (q.cnt == 26'(LEN - 1)) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end else if (start) begin
      d.busy = 1'b1;
      d.cnt  = '0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) q <= '0;
    else q <= d;
  end

  assign busy = q.busy;
  assign done = q.done;

  a_busy_bound:
  assert property (@(posedge pclk) disable iff (!presetn) q.busy |-> q.cnt < 26'(LEN))
    else $error("busy run exceeds its length");
  a_done_time:
  assert property (@(posedge pclk) disable iff (!presetn) $fell(q.busy) |-> q.done && $past(q.cnt) == 26'(LEN - 1))
    else $error("busy ended at wrong count");
endmodule : busy_timer

// File: slot_engine.sv
// bit-slot engine on the open-drain data line
// assumes dq_in is synchronous to pclk
`timescale 1ns/100ps
`include "sense_defs.svh"
module slot_engine #(
  parameter int unsigned RESET_CYC = `RESET_CYC,
  parameter int unsigned PRES_CYC  = `PRES_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic dq_in,
  slot_if.eng       sl
);
  import sense_pkg::*;
  eng_q_t q, d;

  // slot timing counts from the master's falling edge, presence timing from its rising edge
  always_comb begin
    d = q;
    d.strobe = 1'b0;
    d.rst    = 1'b0;
    d.prev   = dq_in;
    case (q.st)
      E_IDLE: begin
        if (q.prev && !dq_in) begin
          d.st  = E_SLOT;
          d.cnt = 16'h1;
          d.oe  = sl.tx_en & ~sl.tx_bit;
        end
      end
      E_SLOT: begin
        d.cnt = q.cnt + 16'h1;
        if (q.cnt == 16'(`HOLD_CYC)) d.oe = 1'b0;
        if (q.cnt == 16'(`SAMPLE_CYC)) begin
          d.strobe = 1'b1;
          d.val    = dq_in;
        end
        if (q.cnt > 16'(`SAMPLE_CYC) && dq_in) d.st = E_IDLE;
        else if (q.cnt == 16'(RESET_CYC) && !dq_in) begin
          d.st  = E_RLOW;
          d.rst = 1'b1;
        end
      end
      E_RLOW: begin
        if (dq_in) begin
          d.st  = E_PWAIT;
          d.cnt = 16'h1;
        end
      end
      E_PWAIT: begin
        d.cnt = q.cnt + 16'h1;
        if (q.cnt == 16'(`PWAIT_CYC)) begin
          d.st  = E_PRES;
          d.oe  = 1'b1;
          d.cnt = 16'h1;
        end
      end
      E_PRES: begin
        d.cnt = q.cnt + 16'h1;
        if (q.cnt == 16'(PRES_CYC)) begin
          d.st = E_IDLE;
          d.oe = 1'b0;
        end
      end
      default: d.st = E_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) q <= '{st: E_IDLE, prev: 1'b1, default: '0};
    else q <= d;
  end

  assign sl.rst_pulse  = q.rst;
  assign sl.bit_strobe = q.strobe;
  assign sl.bit_val    = q.val;
  assign sl.dq_oe      = q.oe;

  a_write_sample:
  assert property (@(posedge pclk) disable iff (!presetn)
    q.strobe |-> $past(q.cnt) > 16'(`HOLD_CYC) && $past(q.cnt) < 16'd3000)
    else $error("write sample outside window");
  a_read_hold:
  assert property (@(posedge pclk) disable iff (!presetn)
    $fell(q.oe) && $past(q.st) == E_SLOT |-> $past(q.cnt) == 16'(`HOLD_CYC))
    else $error("read bit not held for its window");
  a_pres_len:
  assert property (@(posedge pclk) disable iff (!presetn)
    $fell(q.oe) && $past(q.st) == E_PRES |-> $past(q.cnt) == 16'(PRES_CYC))
    else $error("presence pulse wrong length");
endmodule : slot_engine

// File: sensor_fn_top.sv
// function-command logic of a single-wire temperature sensor
// assumes an APB master on pclk and an external pullup on the line
`timescale 1ns/100ps
`include "sense_defs.svh"

module sensor_fn_top #(
  parameter int unsigned RESET_CYC = `RESET_CYC,
  parameter int unsigned PRES_CYC  = `PRES_CYC,
  parameter int unsigned CONV_CYC  = `CONV_CYC,
  parameter int unsigned COPY_CYC  = `COPY_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dq_in,
  output logic             dq_out,
  output logic             dq_oe
);
  import sense_pkg::*;

  fn_q_t      q, d;
  logic       conv_busy;
  logic       conv_done;
  logic       copy_busy;
  logic       copy_done;
  logic [7:0] rx_nx;
  logic [7:0] crc_nx;
  logic       fb;

  slot_if sl ();

  slot_engine #(
    .RESET_CYC (RESET_CYC),
    .PRES_CYC  (PRES_CYC)
  ) u_eng (
    .pclk    (pclk),
    .presetn (presetn),
    .dq_in   (dq_in),
    .sl      (sl.eng)
  );

  busy_timer #(.LEN(CONV_CYC)) u_conv (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (q.conv_go),
    .busy    (conv_busy),
    .done    (conv_done)
  );

  busy_timer #(.LEN(COPY_CYC)) u_copy (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (q.copy_go),
    .busy    (copy_busy),
    .done    (copy_done)
  );

  // mapped register offsets
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `REG_CTRL) || (a == `REG_SRC) || (a == `REG_STAT)
           || (a == `REG_TRIG) || (a == `REG_TEMP);
  endfunction : reg_hit

  // scratchpad byte by index, crc byte handled apart
  function automatic logic [7:0] sp_byte(input fn_q_t s, input logic [3:0] i);
    case (i)
      4'h0:    sp_byte = s.temp[7:0];
      4'h1:    sp_byte = s.temp[15:8];
      4'h2:    sp_byte = s.hi;
      4'h3:    sp_byte = s.lo;
      4'h6:    sp_byte = s.temp[23:16];
      4'h7:    sp_byte = s.temp[31:24];
      default: sp_byte = `SP_RSVD;
    endcase
  endfunction : sp_byte

  // next received byte and running crc, lsb first
  assign rx_nx  = {sl.bit_val, q.rx[7:1]};
  assign fb     = q.crc[0] ^ q.txb[0];
  assign crc_nx = {1'b0, q.crc[7:1]} ^ (fb ? `CRC_POLY : 8'h00);

  // bit returned in read slots; idle states read as 1
  always_comb begin
    sl.tx_en  = 1'b1;
    sl.tx_bit = 1'b1;
    case (q.st)
      F_RDSP: sl.tx_bit = q.txb[0];
      F_CONV: sl.tx_bit = ~conv_busy;
      F_COPY: sl.tx_bit = ~copy_busy;
      F_PWR:  sl.tx_bit = q.ext_pwr;
      default: sl.tx_en = 1'b0;
    endcase
  end

  // next state: bus, background events, then line bits
  always_comb begin
    d = q;
    d.conv_go = 1'b0;
    d.copy_go = 1'b0;
    d.recall  = 1'b0;
    // apb answers in the first access cycle
    d.pready  = psel & ~penable;
    d.pslverr = psel & ~penable & ~reg_hit(paddr);
    d.prdata  = '0;
    if (psel && !penable && !pwrite && reg_hit(paddr)) begin
      if (paddr == `REG_CTRL) d.prdata = {31'h0, q.ext_pwr};
      else if (paddr == `REG_SRC) d.prdata = q.src;
      else if (paddr == `REG_STAT) d.prdata = {16'h0000, q.st, 6'h00, copy_busy, conv_busy};
      else if (paddr == `REG_TRIG) d.prdata = {q.nv_lo, q.nv_hi, q.lo, q.hi};
      else d.prdata = q.temp;
    end
    // writes land at the edge that samples pready
    if (psel && penable && q.pready && pwrite) begin
      if (paddr == `REG_CTRL) d.ext_pwr = pwdata[`CTRL_EXT_BIT];
      else if (paddr == `REG_SRC) d.src = pwdata;
    end
    if (q.recall) begin
      d.hi = q.nv_hi;
      d.lo = q.nv_lo;
    end
    if (conv_done) d.temp = q.src;
    if (copy_done) begin
      d.nv_hi = q.hi;
      d.nv_lo = q.lo;
    end
    if (sl.rst_pulse) begin
      d.st   = F_ROM;
      d.bits = 3'h0;
    end else if (sl.bit_strobe) begin
      d.bits = q.bits + 3'h1;
      d.rx   = rx_nx;
      d.txb  = {1'b1, q.txb[7:1]};
      case (q.st)
        // only the skip selection is handled here
        F_ROM: begin
          if (q.bits == 3'h7) d.st = (rx_nx == `ROM_SKIP) ? F_FUNC : F_HALT;
        end
        F_FUNC: begin
          if (q.bits == 3'h7) begin
            d.idx = 4'h0;
            if (rx_nx == `CMD_CONV) begin
              d.conv_go = 1'b1;
              d.st      = F_CONV;
            end else if (rx_nx == `CMD_RECALL) begin
              d.recall = 1'b1;
              d.st     = F_CONV;
            end else if (rx_nx == `CMD_POWER) d.st = F_PWR;
            else if (rx_nx == `CMD_COPY) begin
              d.copy_go = 1'b1;
              d.st      = F_COPY;
            end else if (rx_nx == `CMD_WRITE) d.st = F_WRT;
            else if (rx_nx == `CMD_READ) begin
              d.st  = F_RDSP;
              d.crc = 8'h00;
              d.txb = sp_byte(q, 4'h0);
            end else d.st = F_HALT;
          end
        end
        F_WRT: begin
          if (q.bits == 3'h7) begin
            if (q.idx == 4'h0) begin
              d.hi  = rx_nx;
              d.idx = 4'h1;
            end else begin
              d.lo = rx_nx;
              d.st = F_HALT;
            end
          end
        end
        F_RDSP: begin
          if (q.idx != `SP_LAST) d.crc = crc_nx;
          if (q.bits == 3'h7) begin
            d.idx = q.idx + 4'h1;
            if (q.idx == `SP_LAST) d.st = F_HALT;
            else if (q.idx + 4'h1 == `SP_LAST) d.txb = crc_nx;
            else d.txb = sp_byte(q, q.idx + 4'h1);
          end
        end
        default: ;
      endcase
    end
  end

  // state register; store and triggers start equal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: F_HALT, nv_hi: `NV_HIGH_RST, nv_lo: `NV_LOW_RST,
             hi: `NV_HIGH_RST, lo: `NV_LOW_RST, src: `SRC_RST,
             recall: 1'b1, txb: 8'hFF, default: '0};
    end else begin
      q <= d;
    end
  end

  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign dq_out  = q.dq_out;
  assign dq_oe   = sl.dq_oe;

  a_conv_start:
  assert property (@(posedge pclk) disable iff (!presetn)
    q.st == F_FUNC && sl.bit_strobe && !sl.rst_pulse && q.bits == 3'h7 && rx_nx == `CMD_CONV
      |=> q.st == F_CONV ##1 conv_busy)
    else $error("conversion did not start");
  a_conv_bit:
  assert property (@(posedge pclk) disable iff (!presetn)
    q.st == F_CONV |-> sl.tx_en && (sl.tx_bit != conv_busy))
    else $error("busy bit wrong during conversion");
  a_recall_load:
  assert property (@(posedge pclk) disable iff (!presetn)
    q.recall |=> q.hi == $past(q.nv_hi) && q.lo == $past(q.nv_lo))
    else $error("trigger reload missing");
  a_power_bit:
  assert property (@(posedge pclk) disable iff (!presetn)
    q.st == F_PWR |-> sl.tx_en && sl.tx_bit == q.ext_pwr)
    else $error("supply mode bit wrong");
  a_trig_write:
  assert property (@(posedge pclk) disable iff (!presetn)
    q.st == F_WRT && sl.bit_strobe && !sl.rst_pulse && q.bits == 3'h7 && q.idx == 4'h0
      |=> q.hi == $past(rx_nx) && q.st == F_WRT)
    else $error("high trigger not stored");
  a_copy_bit:
  assert property (@(posedge pclk) disable iff (!presetn)
    q.st == F_COPY |-> sl.tx_bit == !copy_busy)
    else $error("copy progress bit wrong");
  a_read_end:
  assert property (@(posedge pclk) disable iff (!presetn)
    q.st == F_RDSP |-> q.idx <= `SP_LAST)
    else $error("scratchpad read ran past crc byte");
  a_reset_abort:
  assert property (@(posedge pclk) disable iff (!presetn)
    sl.rst_pulse |=> q.st == F_ROM && q.bits == 3'h0)
    else $error("reset did not abort command");
endmodule : sensor_fn_top

// File: line_master.sv
// single-wire bus master model, owner of the far end of the data line
// assumes pclk at 50 MHz (50 cycles per microsecond) and a pullup on the wire
`timescale 1ns/100ps
module line_master (
  input  wire logic pclk,
  input  wire logic dq_oe,
  output logic      line
);
  logic m_oe;

  initial m_oe = 1'b0;

  // wired-and of both pull-downs; the pullup wins when nobody drives
  assign line = ~(m_oe | dq_oe);

  // plain pullup only
  // parasite supply: line left high, no slot until the busy time is over
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask : hold

  // read sampling
  // n cycles low from the fall, sample at 13 us, 60 us slot, 1 us recovery
  task automatic slot(input int n, output logic b);
    @(posedge pclk);
    m_oe <= 1'b1;
    for (int i = 0; i < 3050; i++) begin
      @(posedge pclk);
      if (i == n - 1) m_oe <= 1'b0;
      if (i == 650) b = line;
    end
  endtask : slot

  // bytes go out lsb first: a one releases after 1 us, a zero holds 60 us
  task automatic wr_byte(input logic [7:0] v);
    logic b;
    for (int i = 0; i < 8; i++) slot(v[i] ? 50 : 3000, b);
  endtask : wr_byte

  task automatic rd_byte(output logic [7:0] v);
    logic b;
    for (int i = 0; i < 8; i++) begin
      slot(50, b);
      v[i] = b;
    end
  endtask : rd_byte

  // reset pulse, then time the rise-to-presence gap and the presence width
  task automatic bus_reset(input int rc, output int dly, output int len);
    @(posedge pclk);
    m_oe <= 1'b1;
    repeat (rc + 100) @(posedge pclk);
    m_oe <= 1'b0;
    @(posedge pclk);
    dly = 1;
    len = 0;
    while (line !== 1'b0 && dly < 4000) begin
      @(posedge pclk);
      dly++;
    end
    while (line === 1'b0 && len < 20000) begin
      @(posedge pclk);
      len++;
    end
    repeat (1000) @(posedge pclk);
  endtask : bus_reset
endmodule : line_master

// File: sensor_fn_top_tb.sv
// self-checking bench for the sensor function-command block
// drives APB directly and the data line through the master model
`timescale 1ns/100ps
`include "sense_defs.svh"
module sensor_fn_top_tb;
  // short reset, presence and busy counts keep the run in milliseconds
  localparam int RC = 4000;
  localparam int PC = 100;
  localparam int CV = 70000;
  localparam int CP = 10000;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        dq_out;
  logic        dq_oe;
  logic        line;
  logic [31:0] rdd;
  logic        rde;
  int          fails;
  int          n_compared;

  sensor_fn_top #(.RESET_CYC(RC), .PRES_CYC(PC), .CONV_CYC(CV), .COPY_CYC(CP)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dq_in(line), .dq_out(dq_out), .dq_oe(dq_oe)
  );

  line_master m (.pclk(pclk), .dq_oe(dq_oe), .line(line));

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // one transfer; the request stands until pready is seen at an edge, for at most 20 edges
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // a slave that never answers counts against the run
    if (pready !== 1'b1) check("pready", pready, 32'h0000_0001);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] msk, exp);
    apb(1'b0, a, 32'h0000_0000, rdd, rde);
    check(what, rdd & msk, exp);
  endtask : rchk

  // reset, skip the rom stage, then issue one function byte
  task automatic cmd(input logic [7:0] code);
    int dly;
    int len;
    m.bus_reset(RC, dly, len);
    m.wr_byte(`ROM_SKIP);
    m.wr_byte(code);
  endtask : cmd

  // keep reading slots until a one comes back, within a bound
  task automatic poll(input string what, input int bound);
    logic b;
    int   n;
    n = 0;
    b = 1'b0;
    while (b !== 1'b1 && n < bound) begin
      m.slot(50, b);
      n++;
    end
    check(what, b, 32'h0000_0001);
  endtask : poll

  task automatic t_powerup();
    rchk("trig", `REG_TRIG, 32'hFFFF_FFFF, {`NV_LOW_RST, `NV_HIGH_RST, `NV_LOW_RST, `NV_HIGH_RST});
    apb(1'b0, 8'h40, 32'h0000_0000, rdd, rde);
    check("slverr", rde, 32'h0000_0001);
    check("unmapped", rdd, 32'h0000_0000);
    check("dq_out", dq_out, 32'h0000_0000);
    $display("test powerup finished");
  endtask : t_powerup

  task automatic t_presence();
    int dly;
    int len;
    m.bus_reset(RC, dly, len);
    check("gap", dly >= 750 && dly <= 3000, 32'h0000_0001);
    check("width", len >= PC - 1 && len <= PC + 1, 32'h0000_0001);
    $display("test presence finished");
  endtask : t_presence

  task automatic t_scratch();
    logic b;
    // external supply, so the line may be polled while busy
    apb(1'b1, `REG_CTRL, 32'h0000_0001, rdd, rde);
    apb(1'b1, `REG_SRC, 32'h0000_1234, rdd, rde);
    cmd(`CMD_WRITE);
    m.wr_byte(8'hA5);
    m.wr_byte(8'h3C);
    rchk("trig", `REG_TRIG, 32'h0000_FFFF, 32'h0000_3CA5);
    cmd(`CMD_COPY);
    m.slot(50, b);
    check("copy busy", b, 32'h0000_0000);
    poll("copy done", CP / 3050 + 3);
    rchk("store", `REG_TRIG, 32'hFFFF_0000, 32'h3CA5_0000);
    $display("test scratch finished");
  endtask : t_scratch

  task automatic t_conv_recall();
    logic       b;
    logic [7:0] v;
    logic [7:0] c;
    int         dly;
    int         len;
    cmd(`CMD_WRITE);
    m.wr_byte(8'h11);
    m.wr_byte(8'h22);
    cmd(`CMD_CONV);
    m.slot(50, b);
    check("conv busy", b, 32'h0000_0000);
    // conversion timer outlives the line reset, so recall still reads busy
    cmd(`CMD_RECALL);
    rchk("recall", `REG_TRIG, 32'h0000_FFFF, 32'h0000_3CA5);
    m.slot(50, b);
    check("recall busy", b, 32'h0000_0000);
    poll("conv done", CV / 3050 + 3);
    rchk("idle", `REG_STAT, 32'h0000_0001, 32'h0000_0000);
    rchk("temp", `REG_TEMP, 32'hFFFF_FFFF, 32'h0000_1234);
    cmd(`CMD_READ);
    c = 8'h00;
    // whole scratchpad, crc kept over what was received
    for (int i = 0; i < 8; i++) begin
      m.rd_byte(v);
      check("scratch byte", v, {24'h0, 8'(64'h0000_FFFF_3CA5_1234 >> (8 * i))});
      for (int j = 0; j < 8; j++) c = {1'b0, c[7:1]} ^ ((c[0] ^ v[j]) ? `CRC_POLY : 8'h00);
    end
    m.rd_byte(v);
    check("crc byte", v, {24'h0, c});
    m.bus_reset(RC, dly, len);
    rchk("state", `REG_STAT, 32'h0000_FF00, 32'h0000_0200);
    $display("test conv_recall finished");
  endtask : t_conv_recall

  task automatic t_power();
    logic b;
    apb(1'b1, `REG_CTRL, 32'h0000_0001, rdd, rde);
    rchk("ctrl", `REG_CTRL, 32'hFFFF_FFFF, 32'h0000_0001);
    cmd(`CMD_POWER);
    m.slot(50, b);
    check("external", b, 32'h0000_0001);
    apb(1'b1, `REG_CTRL, 32'h0000_0000, rdd, rde);
    m.slot(50, b);
    check("parasite", b, 32'h0000_0000);
    // parasite supply: the conversion runs with the line only pulled up
    apb(1'b1, `REG_SRC, 32'h0000_5678, rdd, rde);
    cmd(`CMD_CONV);
    rchk("conv run", `REG_STAT, 32'h0000_0001, 32'h0000_0001);
    m.hold(CV + 100);
    rchk("conv end", `REG_STAT, 32'h0000_0001, 32'h0000_0000);
    rchk("temp", `REG_TEMP, 32'hFFFF_FFFF, 32'h0000_5678);
    $display("test power finished");
  endtask : t_power

  // main sequence
  initial begin
    fails = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_powerup();
    t_presence();
    t_scratch();
    t_conv_recall();
    t_power();
    give_verdict();
  end

  // whole run is near 18 ms of line traffic
  initial begin
    #25_000_000;
    fails++;
    give_verdict();
  end
endmodule : sensor_fn_top_tb
